// File: src/fosr_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "fosr_regs.svh"

module fosr_host
   import fosr_pkg::*;
#(
   parameter int AW = 23
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [AW-1:0] flashAddr,
   input wire logic [15:0] flashDqIn,
   output logic [15:0] flashDqOut,
   output logic flashDqOe_n,
   output logic flashCe_n,
   output logic flashOe_n,
   output logic flashWe_n,
   input wire logic readyBusyOut
);

   localparam logic [3:0] STROBE_CYC = 4'(`FOSR_STROBE_CYC);
   localparam logic [3:0] READ_CYC = 4'(`FOSR_STROBE_CYC + `FOSR_SYNC_CYC);

   typedef struct packed {
      fosr_state_type state;
      fosr_op_type op;
      logic [3:0] cnt;
      logic busy;
      logic done;
      logic fail;
      logic tmo;
      logic fin;
      logic [AW-1:0] addr;
      logic [15:0] data;
      logic [15:0] rd;
      logic [15:0] result;
      logic [31:0] prdata;
      logic pslverr;
      logic [AW-1:0] flAddr;
      logic [15:0] dqOut;
      logic dqOe_n;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } fosr_regs_type;

   fosr_regs_type s;
   fosr_regs_type next_s;
   logic [15:0] dqSync;
   logic readySync;
   logic target;
   logic isPoll;

   fosr_sync2 #(.W(16)) u_dq_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(flashDqIn),
      .dout(dqSync)
   );

   fosr_sync2 #(.W(1)) u_rb_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(readyBusyOut),
      .dout(readySync)
   );

   assign isPoll = (s.op == OP_PROG) || (s.op == OP_ERASE);
   // program polls against bit 7 of the written data, erase against one
   assign target = (s.op == OP_PROG) ? s.data[`FOSR_POLL_BIT] : 1'b1;

   always_comb begin
      next_s = s;
      // read data is latched in the setup cycle so it comes from a flop
      if (psel && !penable) begin
         next_s.prdata = 32'h0000_0000;
         next_s.pslverr = 1'b0;
         case (paddr)
            `FOSR_OFF_CTRL: begin
               next_s.prdata[`FOSR_CTRL_OP_MSB:0] = s.op;
            end
            `FOSR_OFF_ADDR: begin
               next_s.prdata[AW-1:0] = s.addr;
            end
            `FOSR_OFF_DATA: begin
               next_s.prdata[15:0] = s.data;
            end
            `FOSR_OFF_STAT: begin
               next_s.prdata[`FOSR_STAT_BUSY] = s.busy;
               next_s.prdata[`FOSR_STAT_DONE] = s.done;
               next_s.prdata[`FOSR_STAT_FAIL] = s.fail;
               next_s.prdata[`FOSR_STAT_TMO] = s.tmo;
               next_s.prdata[`FOSR_STAT_READY] = readySync;
            end
            `FOSR_OFF_RESULT: begin
               next_s.prdata[15:0] = s.result;
            end
            default: begin
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      // writes while an operation runs are dropped; busy shows why
      if (psel && penable && pwrite && !s.busy) begin
         case (paddr)
            `FOSR_OFF_CTRL: begin
               if (pwdata[`FOSR_CTRL_OP_MSB:0] <= 3'h3) begin
                  next_s.op = fosr_op_type'(pwdata[`FOSR_CTRL_OP_MSB:0]);
                  next_s.busy = 1'b1;
                  next_s.done = 1'b0;
                  next_s.fail = 1'b0;
                  next_s.tmo = 1'b0;
                  next_s.fin = 1'b0;
                  next_s.result = 16'h0000;
                  if (pwdata[`FOSR_CTRL_OP_MSB:1] == 2'h1) begin
                     next_s.state = ST_RSETUP;
                  end else begin
                     next_s.state = ST_WSETUP;
                  end
               end
            end
            `FOSR_OFF_ADDR: begin
               next_s.addr = pwdata[AW-1:0];
            end
            `FOSR_OFF_DATA: begin
               next_s.data = pwdata[15:0];
            end
            default: begin
            end
         endcase
      end
      case (s.state)
         ST_IDLE: begin
         end
         ST_WSETUP: begin
            next_s.flAddr = AW'(`FOSR_CMD_ADDR);
            if (s.op == OP_CLEAR) begin
               next_s.dqOut = `FOSR_CMD_CLEAR_STATUS;
            end else begin
               next_s.dqOut = `FOSR_CMD_STATUS_READ;
            end
            next_s.dqOe_n = 1'b0;
            next_s.cnt = 4'h0;
            next_s.state = ST_WSTROBE;
         end
         ST_WSTROBE: begin
            next_s.ce_n = 1'b0;
            next_s.we_n = 1'b0;
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == STROBE_CYC) begin
               next_s.ce_n = 1'b1;
               next_s.we_n = 1'b1;
               next_s.state = (s.op == OP_CLEAR) ? ST_DONE : ST_RSETUP;
            end
         end
         ST_RSETUP: begin
            // status overlays any address, polls need the target one
            next_s.dqOe_n = 1'b1;
            next_s.flAddr = s.addr;
            next_s.cnt = 4'h0;
            next_s.state = ST_RSTROBE;
         end
         ST_RSTROBE: begin
            next_s.ce_n = 1'b0;
            next_s.oe_n = 1'b0;
            next_s.cnt = s.cnt + 4'h1;
            // the extra cycles cover the input synchroniser latency
            if (s.cnt == READ_CYC) begin
               next_s.ce_n = 1'b1;
               next_s.oe_n = 1'b1;
               next_s.rd = dqSync;
               next_s.state = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (!isPoll) begin
               if (s.rd[`FOSR_READY_BIT]) begin
                  next_s.result = s.rd & `FOSR_KEEP_MASK;
                  next_s.fail = |(s.rd & `FOSR_FAIL_MASK);
                  next_s.state = ST_DONE;
               end else begin
                  // the overlay lasts one read, so reissue the command
                  next_s.state = ST_WSETUP;
               end
            end else if (s.rd[`FOSR_POLL_BIT] == target) begin
               if (s.fin) begin
                  next_s.result = s.rd;
                  next_s.state = ST_DONE;
               end else begin
                  // the low bits may lag the polling bit by one read
                  next_s.fin = 1'b1;
                  next_s.state = ST_RSETUP;
               end
            end else if (s.rd[`FOSR_TMO_BIT]) begin
               if (s.tmo) begin
                  next_s.fail = 1'b1;
                  next_s.result = s.rd;
                  next_s.state = ST_DONE;
               end else begin
                  next_s.tmo = 1'b1;
                  next_s.state = ST_RSETUP;
               end
            end else begin
               next_s.state = ST_RSETUP;
            end
         end
         ST_DONE: begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.state = ST_IDLE;
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.dqOe_n <= 1'b1;
         s.ce_n <= 1'b1;
         s.oe_n <= 1'b1;
         s.we_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign pready = psel && penable;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr;
   assign flashAddr = s.flAddr;
   assign flashDqOut = s.dqOut;
   assign flashDqOe_n = s.dqOe_n;
   assign flashCe_n = s.ce_n;
   assign flashOe_n = s.oe_n;
   assign flashWe_n = s.we_n;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   status_ready_a: assert property (
      $rose(s.done) && !isPoll && s.op != OP_CLEAR
      |-> s.result[`FOSR_READY_BIT] && $past(s.rd[`FOSR_READY_BIT], 2))
      else $error("status reported while device busy");

   status_mask_a: assert property (
      s.done && s.op == OP_STATUS |-> s.result[15:8] == 8'h00 && !s.result[0])
      else $error("reserved status bits not masked");

   suspend_wait_a: assert property (
      s.state == ST_EVAL && s.op == OP_STATUS && !s.rd[`FOSR_READY_BIT]
      |=> s.state == ST_WSETUP ##1 s.state == ST_WSTROBE && !s.done)
      else $error("status polling stopped while busy");

   prog_addr_a: assert property (
      s.state == ST_RSTROBE && s.op == OP_PROG |-> flashAddr == s.addr)
      else $error("program poll not at target address");

   erase_addr_a: assert property (
      s.state == ST_RSTROBE && s.op == OP_ERASE && !flashOe_n
      |-> flashAddr == s.addr && flashDqOe_n)
      else $error("erase poll not at sector address");

   final_read_a: assert property (
      s.state == ST_EVAL && isPoll && !s.fin && s.rd[`FOSR_POLL_BIT] == target
      |=> s.fin ##1 s.state == ST_RSTROBE)
      else $error("data taken without a further read");

   tmo_recheck_a: assert property (
      s.state == ST_EVAL && isPoll && !s.tmo && s.rd[`FOSR_TMO_BIT]
      && s.rd[`FOSR_POLL_BIT] != target
      |=> s.tmo && !s.done && s.state == ST_RSETUP)
      else $error("no recheck after timeout bit");

   strobe_excl_a: assert property (
      !flashWe_n |-> flashOe_n && !flashDqOe_n)
      else $error("write strobe overlaps read");

   status_done_c: cover property (
      $rose(s.done) && s.op == OP_STATUS);
   prog_done_c: cover property (
      $rose(s.done) && s.op == OP_PROG && !s.fail);
   erase_fail_c: cover property (
      $rose(s.done) && s.op == OP_ERASE && s.fail);

endmodule : fosr_host

`default_nettype wire

// File: src/fosr_regs.svh
`ifndef FOSR_REGS_SVH
`define FOSR_REGS_SVH

// register offsets on the apb side
`define FOSR_OFF_CTRL 12'h000
`define FOSR_OFF_ADDR 12'h004
`define FOSR_OFF_DATA 12'h008
`define FOSR_OFF_STAT 12'h00C
`define FOSR_OFF_RESULT 12'h010

// control register field
`define FOSR_CTRL_OP_MSB 2

// status register fields
`define FOSR_STAT_BUSY 0
`define FOSR_STAT_DONE 1
`define FOSR_STAT_FAIL 2
`define FOSR_STAT_TMO 3
`define FOSR_STAT_READY 4

// flash status word layout
`define FOSR_READY_BIT 7
`define FOSR_POLL_BIT 7
`define FOSR_TMO_BIT 5
`define FOSR_KEEP_MASK 16'h00FE
`define FOSR_FAIL_MASK 16'h003A

// flash command words and the address they are written to
`define FOSR_CMD_ADDR 32'h0000_0555
`define FOSR_CMD_STATUS_READ 16'h0070
`define FOSR_CMD_CLEAR_STATUS 16'h0071

// strobe timing
`define FOSR_CLK_NS 40
`define FOSR_STROBE_NS 80
`define FOSR_STROBE_CYC ((`FOSR_STROBE_NS + `FOSR_CLK_NS - 1) / `FOSR_CLK_NS)
`define FOSR_SYNC_CYC 2

`endif

// File: src/fosr_pkg.sv
package fosr_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WSETUP = 3'h1,
      ST_WSTROBE = 3'h3,
      ST_RSETUP = 3'h2,
      ST_RSTROBE = 3'h6,
      ST_EVAL = 3'h7,
      ST_DONE = 3'h5
   } fosr_state_type;

   typedef enum logic [2:0] {
      OP_STATUS = 3'h0,
      OP_CLEAR = 3'h1,
      OP_PROG = 3'h2,
      OP_ERASE = 3'h3
   } fosr_op_type;

endpackage : fosr_pkg

// File: src/fosr_sync2.sv
`timescale 1ns/10ps
`default_nettype none

module fosr_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } fosr_sync_type;

   fosr_sync_type s;
   fosr_sync_type next_s;

   // first stage feeds only the second
   always_comb begin
      next_s.meta = din;
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.stable;

endmodule : fosr_sync2

`default_nettype wire

// File: tb/fosr_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "fosr_regs.svh"
module fosr_flash_model #(
   parameter int AW = 23
) (
   input wire logic [AW-1:0] addr,
   input wire logic [15:0] dqIn,
   input wire logic oe_n,
   input wire logic we_n,
   output logic [15:0] dq,
   output logic readyBusy
);
   logic [6:0] flags = 7'h00;
   logic [15:0] arr = 16'h0000;
   logic erase = 1'b0;
   logic tmo = 1'b0;
   logic srPend = 1'b0;
   int busyLeft = 0;
   logic [15:0] word = 16'h0000;
   logic [15:0] last = 16'h0000;
   // reads that a protected target stays busy for before it gives up
   localparam int PROT_READS = 2;
   logic byteMode = 1'b0;
   logic [7:0] lastByte = 8'h00;
   logic pollSrc;
   // in byte mode the polled bit follows the last byte written
   assign pollSrc = byteMode ? lastByte[7] : arr[7];
   assign readyBusy = (busyLeft == 0);
   task start_op(input int dur, input logic isErase, input logic prot,
      input logic inSusp);
      flags = flags & 7'h44;
      erase = isErase;
      busyLeft = prot ? PROT_READS : dur;
      if (!isErase && inSusp && flags[6]) flags[4] = 1'b1;
      if (prot) flags[1] = 1'b1;
   endtask : start_op
   task resume(input logic isErase);
      if (isErase) flags[6] = 1'b0;
      else flags[2] = 1'b0;
   endtask : resume
   // released bus shows the inverse so a stale sample cannot pass
   assign dq = !oe_n ? word : ~last;
   always @(negedge we_n) begin
      if (addr == AW'(`FOSR_CMD_ADDR)) begin
         if (dqIn == `FOSR_CMD_STATUS_READ) srPend = 1'b1;
         if (dqIn == `FOSR_CMD_CLEAR_STATUS) flags = flags & 7'h44;
      end
   end
   always @(negedge oe_n) begin
      if (srPend) begin
         // upper byte is junk on purpose; busy hides the flags
         word = {8'h5A, readyBusy, readyBusy ? flags : 7'h2B};
      end else if (readyBusy) begin
         word = arr;
      end else begin
         word = {arr[15:8], ~erase & ~pollSrc, arr[6], tmo, arr[4:0]};
      end
   end
   always @(posedge oe_n) begin
      last = word;
      srPend = 1'b0;
      if (busyLeft > 0) busyLeft = busyLeft - 1;
   end
endmodule : fosr_flash_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "fosr_regs.svh"
module testbench import fosr_pkg::*;;
   typedef struct {
      logic [2:0] op;
      logic [6:0] fl;
      logic [15:0] arr;
      int busy;
      logic tmo;
      logic [15:0] res;
      logic [4:0] st;
   } fosr_row_type;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr;
   logic [22:0] fAddr;
   logic [15:0] dqOut, dqIn, modelDq;
   logic dqOe_n, ce_n, oe_n, we_n, rb;
   int failCount = 0;
   int checks = 0;
   fosr_row_type rows [10] = '{
      '{OP_STATUS, 7'h7F, 16'h0, 0, 1'b0, 16'h00FE, 5'h16},
      '{OP_STATUS, 7'h41, 16'h0, 2, 1'b0, 16'h00C0, 5'h12},
      '{OP_STATUS, 7'h02, 16'h0, 0, 1'b0, 16'h0082, 5'h16},
      '{OP_STATUS, 7'h20, 16'h0, 0, 1'b0, 16'h00A0, 5'h16},
      '{OP_STATUS, 7'h10, 16'h0, 0, 1'b0, 16'h0090, 5'h16},
      '{OP_PROG, 7'h00, 16'h1234, 3, 1'b0, 16'h1234, 5'h12},
      '{OP_PROG, 7'h00, 16'h00A5, 1, 1'b0, 16'h00A5, 5'h12},
      '{OP_ERASE, 7'h00, 16'hFFFF, 2, 1'b0, 16'hFFFF, 5'h12},
      '{OP_PROG, 7'h00, 16'h0080, 1, 1'b1, 16'h0080, 5'h1A},
      '{OP_ERASE, 7'h00, 16'h0F0F, 100, 1'b1, 16'h0F2F, 5'h0E}};
   assign dqIn = dqOe_n ? modelDq : dqOut;
   always #20 clk = ~clk;
   fosr_host u_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flashAddr(fAddr),
      .flashDqIn(dqIn), .flashDqOut(dqOut), .flashDqOe_n(dqOe_n),
      .flashCe_n(ce_n), .flashOe_n(oe_n), .flashWe_n(we_n),
      .readyBusyOut(rb));
   fosr_flash_model u_flash (.addr(fAddr), .dqIn(dqOut), .oe_n(oe_n),
      .we_n(we_n), .dq(modelDq), .readyBusy(rb));
   task tally_and_finish;
      if (failCount == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task check(input string name, input logic [31:0] got,
      input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // the leading edge keeps psel from being driven twice in one step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task run(input logic [2:0] op);
      apb(1'b1, `FOSR_OFF_CTRL, {29'h0, op});
      for (int i = 0; i < 400; i++) begin
         apb(1'b0, `FOSR_OFF_STAT, 32'h0);
         if (rdat[`FOSR_STAT_DONE] === 1'b1 && rdat[0] === 1'b0) break;
      end
   endtask : run
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         u_flash.flags = rows[i].fl;
         u_flash.arr = rows[i].arr;
         u_flash.busyLeft = rows[i].busy;
         u_flash.tmo = rows[i].tmo;
         u_flash.erase = (rows[i].op == OP_ERASE);
         apb(1'b1, `FOSR_OFF_ADDR, 32'h0000_1230);
         apb(1'b1, `FOSR_OFF_DATA, {16'h0, rows[i].arr});
         run(rows[i].op);
         check("stat", rdat, {27'h0, rows[i].st});
         apb(1'b0, `FOSR_OFF_RESULT, 32'h0);
         check("result", rdat, {16'h0, rows[i].res});
      end
      // clear must leave the suspend flags standing
      u_flash.flags = 7'h7F;
      u_flash.busyLeft = 0;
      u_flash.tmo = 1'b0;
      run(OP_CLEAR);
      run(OP_STATUS);
      apb(1'b0, `FOSR_OFF_RESULT, 32'h0);
      check("clear", rdat, 32'h0000_00C4);
      // resume drops only the erase suspend flag
      u_flash.flags = 7'h44;
      u_flash.resume(1'b1);
      run(OP_STATUS);
      apb(1'b0, `FOSR_OFF_RESULT, 32'h0);
      check("resume", rdat, 32'h0000_0084);
      // program into the suspended erase sector fails
      u_flash.flags = 7'h7F;
      u_flash.start_op(1, 1'b0, 1'b0, 1'b1);
      run(OP_STATUS);
      apb(1'b0, `FOSR_OFF_RESULT, 32'h0);
      check("susp prog", rdat, 32'h0000_00D4);
      // protected targets end early and flag the lock
      for (int k = 0; k < 2; k++) begin
         u_flash.flags = 7'h00;
         u_flash.start_op(5000, k[0], 1'b1, 1'b0);
         run(OP_STATUS);
         apb(1'b0, `FOSR_OFF_RESULT, 32'h0);
         check("prot", rdat, 32'h0000_0082);
      end
      apb(1'b0, 12'h014, 32'h0);
      check("slverr", {31'h0, rerr}, 32'h0000_0001);
      check("unmapped", rdat, 32'h0000_0000);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // the ready pin needs two edges through its synchroniser
      repeat (2) @(posedge clk);
      apb(1'b0, `FOSR_OFF_STAT, 32'h0);
      check("rst stat", rdat, 32'h0000_0010);
      apb(1'b0, `FOSR_OFF_RESULT, 32'h0);
      check("rst result", rdat, 32'h0000_0000);
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      tally_and_finish;
   end
endmodule : testbench
`default_nettype wire
